// ---- design/stc_pkg.sv ----
// Purpose: shared constants and state types of the sixteen bit timer counter
// Assumes: 32-bit APB, byte addresses, one register per aligned word
// Notes: clk_i is the oscillator clock; the instruction cycle is four of it
package stc_pkg;
  localparam int STC_ADDR_W = 12;
  localparam logic [11:0] STC_OFF_CTRL = 12'h010;
  localparam logic [11:0] STC_OFF_CNT_LO = 12'h014;
  localparam logic [11:0] STC_OFF_CNT_HI = 12'h018;
  localparam logic [11:0] STC_OFF_FLAG = 12'h01C;
  localparam logic [11:0] STC_OFF_IRQEN = 12'h020;
  localparam int STC_RUN_BIT = 0;
  localparam int STC_CS_BIT = 1;
  localparam int STC_NOSYNC_BIT = 2;
  localparam int STC_OSC_BIT = 3;
  localparam int STC_PS_LSB = 4;
  localparam int STC_PS_MSB = 5;
  localparam int STC_FLAG_BIT = 0;
  localparam int STC_IRQEN_BIT = 0;
  localparam logic [7:0] STC_CTRL_MASK = 8'h3F;
  localparam logic [7:0] STC_CTRL_RST = 8'h00;
  localparam logic [15:0] STC_CNT_MAX = 16'hFFFF;
  localparam logic [15:0] STC_CNT_ZERO = 16'h0000;
  localparam int STC_CLK_MHZ = 250;
  localparam int STC_OSC_PER_INSTR = 4;
  localparam logic [1:0] STC_PHASE_LAST = 2'(STC_OSC_PER_INSTR - 1);
  localparam logic [1:0] STC_PS_DIV1 = 2'h0;
  localparam logic [1:0] STC_PS_DIV2 = 2'h1;
  localparam logic [1:0] STC_PS_DIV4 = 2'h2;
  localparam logic [1:0] STC_PS_DIV8 = 2'h3;

  typedef struct packed {
    logic [2:0] cnt;
    logic tick;
  } stc_presc_type;

  typedef struct packed {
    logic [7:0] ctrl;
    logic flag;
    logic irq_en;
    logic armed;
    logic src_prev;
    logic [1:0] phase;
    logic sync_tick;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic irq;
    logic [1:0] pin_rd;
    logic osc_on;
  } stc_main_type;
endpackage

// ---- design/stc_presc_if.sv ----
// Purpose: carrier between the timer core and its prescaler
// Assumes: both ends run on clk_i
// Notes: edge and clear are one-cycle pulses, tick is one cycle from a flop
`timescale 1ns/1ps
interface stc_presc_if;
  logic edge_in;
  logic clear;
  logic [1:0] sel;
  logic tick;
  modport ctrl (output edge_in, output clear, output sel, input tick);
  modport presc (input edge_in, input clear, input sel, output tick);
endinterface

// ---- design/stc_prescaler.sv ----
// Purpose: 1/2/4/8 divider of count edges
// Assumes: edge_in pulses at most once per cycle
// Notes: a clear wins over an arriving edge
`timescale 1ns/1ps
module stc_prescaler
  import stc_pkg::*;
(
  input wire logic clk_i,
  input wire logic arst_n_i,
  stc_presc_if.presc pif
);
  stc_presc_type state;
  stc_presc_type next_state;

  function automatic logic [2:0] stc_div_limit(input logic [1:0] sel);
    case (sel)
      STC_PS_DIV1: stc_div_limit = 3'h0;
      STC_PS_DIV2: stc_div_limit = 3'h1;
      STC_PS_DIV4: stc_div_limit = 3'h3;
      default: stc_div_limit = 3'h7;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_state = state;
    next_state.tick = 1'b0;
    if (pif.clear) begin
      next_state.cnt = 3'h0;
    end else if (pif.edge_in) begin
      if (state.cnt >= stc_div_limit(pif.sel)) begin
        next_state.cnt = 3'h0;
        next_state.tick = 1'b1;
      end else begin
        next_state.cnt = state.cnt + 3'h1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign pif.tick = state.tick;

  ////////////////////////////////////////////////////////////////////////////
  presc_clear_a: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    pif.clear |=> (state.cnt == 3'h0) && !state.tick)
    else $error("prescaler not cleared");

  presc_div8_a: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    ($past(pif.sel) == STC_PS_DIV8) && state.tick && !$past(pif.clear) |-> $past(state.cnt) == 3'h7)
    else $error("divide by eight tick at wrong count");
endmodule

// ---- design/stc_timer.sv ----
// Purpose: sixteen bit timer counter with APB registers
// Assumes: all pins synchronous to clk_i; clk_i is the oscillator clock
// Notes: count bytes have no reset; software must load them first
// Behaviour
// - sixteen bit up count, two bytes, wraps
// - wrap sets sticky overflow flag bit 0
// - enable bit 0 gates flag to irq
// - control bit 1 picks external or internal
// - timer mode counts once per instruction cycle
// - counter mode counts rising edges only
// - counter mode waits for first falling edge
// - control bit 0 runs; stopped holds count
// - bits 5:4 divide by 1/2/4/8
// - bit 2 zero synchronises external input
// - internal mode ignores synchronise bit
// - bit 3 powers dedicated oscillator inverter
// - oscillator on forces pins input, read zero
// - either compare unit can clear count
// - control bits 7:6 read zero, others RW
// - synchronisation sits after the prescaler
// - software write beats compare clear
// - count write clears the prescaler
// - power reset clears control, not count
//
// The APB register port was left to the implementer.
`timescale 1ns/1ps
module stc_timer
  import stc_pkg::*;
(
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic external_count_pin_i,
  input wire logic osc_input_pin_i,
  input wire logic compare_reset_a_i,
  input wire logic compare_reset_b_i,
  input wire logic [1:0] port_pins_i,
  output logic [1:0] port_pins_read_o,
  output logic osc_pins_force_input_o,
  output logic osc_inverter_enable_o,
  output logic overflow_irq_o
);
  stc_main_type state;
  stc_main_type next_state;
  logic [15:0] count;
  logic [15:0] next_count;
  logic timer_run;
  logic count_source_select;
  logic no_sync_select;
  logic dedicated_osc_enable;
  logic [1:0] prescale_select;
  logic src;
  logic rise;
  logic fall;
  logic instr_tick;
  logic count_inc;
  logic cmp_clear;
  logic wr_go;
  logic wr_lo;
  logic wr_hi;
  logic cnt_write;
  logic wrap;

  stc_presc_if pif ();

  function automatic logic stc_hit(input logic [11:0] addr, input logic [11:0] off);
    stc_hit = (addr == off);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // control fields
  assign timer_run = state.ctrl[STC_RUN_BIT];
  assign count_source_select = state.ctrl[STC_CS_BIT];
  assign no_sync_select = state.ctrl[STC_NOSYNC_BIT];
  assign dedicated_osc_enable = state.ctrl[STC_OSC_BIT];
  assign prescale_select = state.ctrl[STC_PS_MSB:STC_PS_LSB];

  ////////////////////////////////////////////////////////////////////////////
  // edge sources
  // oscillator input pin when the oscillator runs, else the count pin
  assign src = dedicated_osc_enable ? osc_input_pin_i : external_count_pin_i;
  assign rise = src && !state.src_prev;
  assign fall = !src && state.src_prev;
  assign instr_tick = (state.phase == STC_PHASE_LAST);

  // prescaler sees only armed rising edges or instruction ticks
  assign pif.edge_in = timer_run && (count_source_select ? (rise && state.armed) : instr_tick);
  assign pif.sel = prescale_select;
  assign pif.clear = cnt_write;

  stc_prescaler u_presc (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .pif(pif.presc)
  );

  // synchronised path takes the prescaler output one stage later
  always_comb begin
    if (!count_source_select) begin
      count_inc = pif.tick;
    end else if (no_sync_select) begin
      count_inc = pif.tick;
    end else begin
      count_inc = state.sync_tick;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus decode
  assign wr_go = psel_i && penable_i && state.pready && pwrite_i;
  assign wr_lo = wr_go && stc_hit(paddr_i, STC_OFF_CNT_LO);
  assign wr_hi = wr_go && stc_hit(paddr_i, STC_OFF_CNT_HI);
  assign cnt_write = wr_lo || wr_hi;
  assign cmp_clear = compare_reset_a_i || compare_reset_b_i;
  assign wrap = timer_run && count_inc && (count == STC_CNT_MAX) && !cnt_write && !cmp_clear;

  ////////////////////////////////////////////////////////////////////////////
  // count
  always_comb begin
    next_count = count;
    if (cnt_write) begin
      if (wr_lo) begin
        next_count[7:0] = pwdata_i[7:0];
      end
      if (wr_hi) begin
        next_count[15:8] = pwdata_i[7:0];
      end
    end else if (cmp_clear) begin
      next_count = STC_CNT_ZERO;
    end else if (timer_run && count_inc) begin
      next_count = count + 16'h0001;
    end
  end

  // count is deliberately left out of the reset
  always_ff @(posedge clk_i) begin
    count <= next_count;
  end

  ////////////////////////////////////////////////////////////////////////////
  // state
  always_comb begin
    next_state = state;
    next_state.src_prev = src;
    next_state.phase = state.phase + 2'h1;
    next_state.sync_tick = pif.tick && count_source_select;
    next_state.armed = timer_run && count_source_select && (state.armed || fall);
    next_state.pready = psel_i && penable_i && !state.pready;
    next_state.pslverr = 1'b0;
    if (psel_i && penable_i && !state.pready) begin
      next_state.prdata = 32'h0000_0000;
      if (stc_hit(paddr_i, STC_OFF_CTRL)) begin
        next_state.prdata[7:0] = state.ctrl & STC_CTRL_MASK;
      end else if (stc_hit(paddr_i, STC_OFF_CNT_LO)) begin
        next_state.prdata[7:0] = count[7:0];
      end else if (stc_hit(paddr_i, STC_OFF_CNT_HI)) begin
        next_state.prdata[7:0] = count[15:8];
      end else if (stc_hit(paddr_i, STC_OFF_FLAG)) begin
        next_state.prdata[STC_FLAG_BIT] = state.flag;
      end else if (stc_hit(paddr_i, STC_OFF_IRQEN)) begin
        next_state.prdata[STC_IRQEN_BIT] = state.irq_en;
      end else begin
        next_state.pslverr = 1'b1;
      end
    end
    if (wr_go && stc_hit(paddr_i, STC_OFF_CTRL)) begin
      next_state.ctrl = pwdata_i[7:0] & STC_CTRL_MASK;
    end
    if (wr_go && stc_hit(paddr_i, STC_OFF_FLAG)) begin
      next_state.flag = pwdata_i[STC_FLAG_BIT];
    end
    if (wrap) begin
      next_state.flag = 1'b1;
    end
    if (wr_go && stc_hit(paddr_i, STC_OFF_IRQEN)) begin
      next_state.irq_en = pwdata_i[STC_IRQEN_BIT];
    end
    next_state.irq = next_state.flag && next_state.irq_en;
    next_state.osc_on = next_state.ctrl[STC_OSC_BIT];
    next_state.pin_rd = next_state.ctrl[STC_OSC_BIT] ? 2'h0 : port_pins_i;
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign prdata_o = state.prdata;
  assign pready_o = state.pready;
  assign pslverr_o = state.pslverr;
  assign overflow_irq_o = state.irq;
  assign osc_inverter_enable_o = state.osc_on;
  assign osc_pins_force_input_o = state.osc_on;
  assign port_pins_read_o = state.pin_rd;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  ctrl_top_zero_a: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    state.ctrl[7:6] == 2'h0)
    else $error("control top bits not zero");

  overflow_set_a: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    wrap |=> state.flag && (count == STC_CNT_ZERO) && overflow_irq_o == state.irq_en)
    else $error("wrap did not set flag");

  irq_mask_a: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    !state.irq_en && !wr_go |=> !overflow_irq_o)
    else $error("masked irq forwarded");

  stop_hold_a: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    !timer_run && !cnt_write && !cmp_clear |=> count == $past(count))
    else $error("stopped count moved");

  unarmed_hold_a: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    count_source_select && !state.armed |-> !pif.edge_in)
    else $error("edge taken before falling edge");

  timer_rate_a: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    (timer_run && !count_source_select && prescale_select == STC_PS_DIV1 && instr_tick && !pif.clear)
    |=> pif.tick ##1 !pif.tick [*3])
    else $error("timer mode rate wrong");

  write_wins_a: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    wr_lo && cmp_clear |=> count[7:0] == $past(pwdata_i[7:0]))
    else $error("compare clear beat write");

  cmp_clear_a: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    cmp_clear && !wr_go |=> count == STC_CNT_ZERO && $stable(state.flag))
    else $error("compare clear failed");

  osc_read_zero_a: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    dedicated_osc_enable |-> port_pins_read_o == 2'h0 && osc_pins_force_input_o)
    else $error("oscillator pins not forced");

  sync_delay_a: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    count_source_select && !no_sync_select && $past(count_source_select)
    |-> count_inc == $past(pif.tick))
    else $error("synchronised path not one stage late");

  rise_only_a: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    count_source_select && pif.edge_in |-> src && !state.src_prev)
    else $error("counted a non rising edge");

  armed_rise_a: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    $rose(state.armed) |-> $past(fall))
    else $error("armed without a falling edge");

  armed_drop_a: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    !timer_run || !count_source_select |=> !state.armed)
    else $error("armed kept while stopped");

  inc_step_a: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    timer_run && count_inc && !cnt_write && !cmp_clear |=> count == $past(count) + 16'h0001)
    else $error("count did not step by one");

  flag_sticky_a: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    state.flag && !wr_go |=> state.flag)
    else $error("overflow flag lost");

  irq_follow_a: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    state.flag && state.irq_en |-> overflow_irq_o)
    else $error("enabled overflow not forwarded");

  src_select_a: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    timer_run && count_source_select && state.armed |-> pif.edge_in == rise)
    else $error("external edge not taken");

  instr_rate_a: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    instr_tick |=> !instr_tick [*3] ##1 instr_tick)
    else $error("instruction tick spacing wrong");

  fall_ignored_a: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    count_source_select && fall |-> !pif.edge_in)
    else $error("falling edge counted");

  stop_no_edge_a: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    !timer_run |-> !pif.edge_in)
    else $error("edge taken while stopped");

  nosync_path_a: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    count_source_select && no_sync_select |-> count_inc == pif.tick)
    else $error("unsynchronised path delayed");

  internal_path_a: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    !count_source_select |-> count_inc == pif.tick)
    else $error("internal path depends on sync bit");

  osc_power_a: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    osc_inverter_enable_o == dedicated_osc_enable)
    else $error("oscillator inverter enable wrong");

  pins_pass_a: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    $past(arst_n_i) && !dedicated_osc_enable |-> port_pins_read_o == $past(port_pins_i))
    else $error("port pins not passed through");

  ctrl_reset_a: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    !$past(arst_n_i) |-> state.ctrl == STC_CTRL_RST)
    else $error("control not cleared by reset");

  read_low_a: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    psel_i && penable_i && !state.pready && !pwrite_i && paddr_i == STC_OFF_CNT_LO
    |=> prdata_o == {24'h000000, $past(count[7:0])})
    else $error("low byte read wrong");

  write_high_a: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    wr_hi |=> count[15:8] == $past(pwdata_i[7:0]) && count[7:0] == $past(count[7:0]))
    else $error("high byte write wrong");
endmodule

// ---- test/stc_clk_src.sv ----
// Purpose: model of the external count source feeding the count pins
// Assumes: the source changes just after rising clk_i edges
// Notes: the pin stands still at its last level between bursts
`timescale 1ns/1ps
module stc_clk_src (
  input wire logic clk_i,
  output logic pin_o
);
  initial pin_o = 1'b0;
  // n low-to-high pulses, each level held half cycles
  task automatic burst(input int n, input int half);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_i);
      pin_o <= 1'b1;
      repeat (half) @(posedge clk_i);
      pin_o <= 1'b0;
      repeat (half - 1) @(posedge clk_i);
    end
  endtask
endmodule

// ---- test/tb.sv ----
// Purpose: self-checking bench of the timer counter
// Assumes: one wait state on apb, count pins sampled on clk_i
// Notes: both oscillator and count pins follow one source model
`timescale 1ns/1ps
module tb;
  import stc_pkg::*;
  logic clk_i = 0, arst_n_i = 0, psel = 0, penable = 0, pwrite = 0, cmp_a = 1, cmp_b = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [1:0] port_pins = 2'h3, pins_rd;
  logic pready, pslverr, er, ext_pin, force_in, inv_en, irq;
  int fails = 0, compares = 0, seed = 25544, cycles = 0, v;
  logic [7:0] tm [2] = '{8'h01, 8'h05};
  ////////////////////////////////////////////////////////////////
  always #2 clk_i = ~clk_i;
  stc_clk_src src (.clk_i(clk_i), .pin_o(ext_pin));
  stc_timer uut (.clk_i(clk_i), .arst_n_i(arst_n_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .external_count_pin_i(ext_pin), .osc_input_pin_i(ext_pin),
    .compare_reset_a_i(cmp_a), .compare_reset_b_i(cmp_b), .port_pins_i(port_pins),
    .port_pins_read_o(pins_rd), .osc_pins_force_input_o(force_in), .osc_inverter_enable_o(inv_en),
    .overflow_irq_o(irq));
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      fails = fails + 1;
      results();
    end
  end
  ////////////////////////////////////////////////////////////////
  task automatic results();
    if (fails == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // apb transfer; c drives the compare clears during the access phase
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [1:0] c);
    @(posedge clk_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    {cmp_b, cmp_a} <= c;
    do @(posedge clk_i); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    {cmp_b, cmp_a} <= 2'b00;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 2'b00);
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, 2'b00);
    chk(rd, e);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clk_i);
    arst_n_i <= 1'b1;
    // compare clear held through reset gives the unreset count a known start
    cmp_a <= 1'b0;
    rd_chk(STC_OFF_CTRL, 32'h0);
    rd_chk(STC_OFF_FLAG, 32'h0);
    chk(irq, 1'b0);
    wr(STC_OFF_CTRL, 32'hFF);
    rd_chk(STC_OFF_CTRL, 32'h3F);
    chk({force_in, inv_en, pins_rd}, 32'hC);
    v = $random(seed);
    port_pins <= v[1:0];
    wr(STC_OFF_CTRL, 32'h0);
    repeat (3) @(posedge clk_i);
    chk({force_in, inv_en, pins_rd}, {30'h0, v[1:0]});
    apb(1'b0, 12'h024, 32'h0, 2'b00);
    chk({er, rd[30:0]}, 32'h80000000); // pslverr with zero data
    for (int i = 0; i < 4; i++) begin
      v = $random(seed);
      wr(STC_OFF_CNT_LO, {24'h0, v[7:0]});
      wr(STC_OFF_CNT_HI, {24'h0, v[15:8]});
      rd_chk(STC_OFF_CNT_LO, {24'h0, v[7:0]});
      rd_chk(STC_OFF_CNT_HI, {24'h0, v[15:8]});
    end
    for (int c = 1; c < 3; c++) begin
      wr(STC_OFF_CNT_HI, 32'hAA);
      apb(1'b0, STC_OFF_CTRL, 32'h0, 2'(c));
      rd_chk(STC_OFF_CNT_HI, 32'h0);
    end
    apb(1'b1, STC_OFF_CNT_LO, 32'h5A, 2'b11);
    rd_chk(STC_OFF_CNT_LO, 32'h5A);
    rd_chk(STC_OFF_CNT_HI, 32'h0);
    foreach (tm[i]) begin
      wr(STC_OFF_CNT_HI, 32'h10);
      wr(STC_OFF_CNT_LO, 32'h0);
      wr(STC_OFF_CTRL, {24'h0, tm[i]});
      repeat (400) @(posedge clk_i);
      wr(STC_OFF_CTRL, 32'h0);
      apb(1'b0, STC_OFF_CNT_LO, 32'h0, 2'b00);
      chk(32'(rd >= 99 && rd <= 102), 32'h1);
      v = rd;
      repeat (50) @(posedge clk_i);
      rd_chk(STC_OFF_CNT_LO, 32'(v));
      rd_chk(STC_OFF_CNT_HI, 32'h10);
    end
    for (int p = 0; p < 4; p++) begin
      wr(STC_OFF_CNT_LO, 32'h0);
      wr(STC_OFF_CNT_HI, 32'h0);
      wr(STC_OFF_CTRL, 32'((p << 4) | ((p & 1) << 2) | (p == 3 ? 8 : 0) | 3));
      src.burst(17, 3);
      repeat (10) @(posedge clk_i);
      wr(STC_OFF_CTRL, 32'h0);
      rd_chk(STC_OFF_CNT_LO, 32'(16 >> p));
    end
    wr(STC_OFF_CTRL, 32'h33);
    src.burst(5, 3);
    wr(STC_OFF_CNT_LO, 32'h0);
    src.burst(5, 3);
    repeat (10) @(posedge clk_i);
    wr(STC_OFF_CTRL, 32'h0);
    rd_chk(STC_OFF_CNT_LO, 32'h0);
    wr(STC_OFF_CNT_LO, 32'hF0);
    wr(STC_OFF_CNT_HI, 32'hFF);
    wr(STC_OFF_CTRL, 32'h01);
    repeat (100) @(posedge clk_i);
    wr(STC_OFF_CTRL, 32'h0);
    rd_chk(STC_OFF_CNT_HI, 32'h0);
    rd_chk(STC_OFF_FLAG, 32'h1);
    chk(irq, 1'b0);
    wr(STC_OFF_IRQEN, 32'h1);
    repeat (2) @(posedge clk_i);
    chk(irq, 1'b1);
    wr(STC_OFF_IRQEN, 32'h0);
    repeat (2) @(posedge clk_i);
    chk(irq, 1'b0);
    wr(STC_OFF_FLAG, 32'h0);
    rd_chk(STC_OFF_FLAG, 32'h0);
    results();
  end
endmodule
